// file: rtl/sdc_defs.svh
// constants for the synthesizer divider configuration loader
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
// ==========================================================
// field widths
`define SDC_M_W 9
`define SDC_N_W 2
`define SDC_T_W 2
`define SDC_CNT_W 4
// output divide ratio is the select code plus this base
`define SDC_N_BASE 4'h3
// observe routing codes
`define SDC_T_LOW 2'h0
`define SDC_T_SDATA 2'h1
`define SDC_T_FB 2'h2
`define SDC_T_FOUT 2'h3
// ==========================================================
// reset values of the loaded configuration
`define SDC_M_RST 9'h019
`define SDC_N_RST 2'h1
`define SDC_T_RST 2'h0
// ==========================================================
// register bus
`define SDC_AW 12
`define SDC_DW 32
`define SDC_OFF_CTRL 12'h000
`define SDC_OFF_STATUS 12'h004
`define SDC_OFF_SHIFT 12'h008
`define SDC_CTRL_SOFT_RST 0
`define SDC_RESP_OKAY 2'h0
`define SDC_RESP_SLVERR 2'h2
`endif

// file: rtl/sdc_pkg.sv
// types shared by the divider configuration loader
`include "sdc_defs.svh"
package sdc_pkg;
  // ========================================================
  // one configuration frame, also the serial shift order
  typedef struct packed {
    logic [`SDC_T_W-1:0] t;
    logic [`SDC_N_W-1:0] n;
    logic [`SDC_M_W-1:0] m;
  } sdc_frame_type;

  // read-only status word
  typedef struct packed {
    logic [`SDC_DW-`SDC_M_W-`SDC_N_W-`SDC_T_W-3:0] rsvd;
    logic bypass;
    logic par_mode;
    logic [`SDC_T_W-1:0] t;
    logic [`SDC_N_W-1:0] n;
    logic [`SDC_M_W-1:0] m;
  } sdc_status_type;

  // ========================================================
  // axi4-lite request and response bundles
  typedef struct packed {
    logic awvalid;
    logic [`SDC_AW-1:0] awaddr;
    logic wvalid;
    logic [`SDC_DW-1:0] wdata;
    logic [`SDC_DW/8-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`SDC_AW-1:0] araddr;
    logic rready;
  } sdc_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`SDC_DW-1:0] rdata;
    logic [1:0] rresp;
  } sdc_axi_rsp_type;

  // ========================================================
  // output divider state
  typedef struct packed {
    logic [`SDC_CNT_W-1:0] cnt;
    logic clk_true;
    logic clk_comp;
  } sdc_div_state_type;
endpackage : sdc_pkg

// file: rtl/sdc_out_div.sv
// fifty percent duty output divider counting half periods
`include "sdc_defs.svh"
module sdc_out_div #(
  parameter int SEL_W = `SDC_N_W,
  parameter int CNT_W = `SDC_CNT_W
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic div_rst_i,
  input wire logic half_tick_i,
  input wire logic [SEL_W-1:0] ratio_sel_i,
  output logic clk_true_o,
  output logic clk_comp_o
);
  // ========================================================
  // ratio decode
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] period;
  sdc_pkg::sdc_div_state_type s;
  sdc_pkg::sdc_div_state_type n;

  // counting half periods makes odd ratios symmetric too
  always_comb begin
    half = CNT_W'(CNT_W'(ratio_sel_i) + `SDC_N_BASE);
    period = CNT_W'(half + half);
    n = s;
    if (div_rst_i) begin
      n.cnt = '0;
    end else if (half_tick_i) begin
      // ratio may shrink mid-period, so wrap on >= not ==
      if (s.cnt >= CNT_W'(period - 1'b1)) begin
        n.cnt = '0;
      end else begin
        n.cnt = CNT_W'(s.cnt + 1'b1);
      end
    end
    n.clk_true = !div_rst_i && (n.cnt < half);
    n.clk_comp = !n.clk_true;
  end

  // state register
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '{cnt: '0, clk_true: 1'b0, clk_comp: 1'b1};
    end else begin
      s <= n;
    end
  end

  assign clk_true_o = s.clk_true;
  assign clk_comp_o = s.clk_comp;

  // ========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_DIV_WRAP_HIGH: assert property (
    (!div_rst_i && half_tick_i && s.cnt == CNT_W'(period - 1'b1)
     && $stable(ratio_sel_i)) |=> (s.cnt == '0 && s.clk_true))
    else $error("divider did not restart high at period end");

  AST_DIV_HALF_LOW: assert property (
    (!div_rst_i && half_tick_i && s.cnt == CNT_W'(half - 1'b1)
     && $stable(ratio_sel_i)) |=> (!s.clk_true && s.clk_comp))
    else $error("divider did not fall after half the ratio");
endmodule : sdc_out_div

// file: rtl/sdc_loader.sv
// divider configuration loader with parallel and serial load
`include "sdc_defs.svh"
// Behaviour
// - reset high: true outputs low, complements high
// - reset low: dividers run, outputs enabled
// - reset leaves loaded configuration untouched
// - reference select high crystal, low test clock
// - parallel mode passes pins, observe low
// - parallel load rise latches pins
// - serial clock rise shifts serial data
// - serial load rise transfers shift register
// - serial load fall keeps values in effect
// - no serial clock edge: shift register holds
// - serial load high passes data each clock
// - feedback value is nine-bit unsigned binary
// - select codes give divide three to six
// - bypass input picks pll or bypass path
// - two output pairs from the output divider
// - test bits route the observe output
// - output clock has fifty percent duty
// - vco is reference times feedback value; here a stand-in toggling each core cycle in pll mode, tied to neither
module sdc_loader (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire sdc_pkg::sdc_axi_req_type axi_req_i,
  output sdc_pkg::sdc_axi_rsp_type axi_rsp_o,
  input wire logic divider_reset_i,
  input wire logic parallel_load_low_i,
  input wire logic [`SDC_M_W-1:0] feedback_divide_bits_i,
  input wire logic output_divide_select_low_i,
  input wire logic output_divide_select_high_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_i,
  input wire logic serial_load_i,
  input wire logic reference_source_select_i,
  input wire logic pll_bypass_select_i,
  input wire logic crystal_in_i,
  input wire logic alt_ref_clock_i,
  output logic crystal_out_o,
  output logic clock_out_true_a_o,
  output logic clock_out_comp_a_o,
  output logic clock_out_true_b_o,
  output logic clock_out_comp_b_o,
  output logic observe_o
);
  // ========================================================
  // state
  typedef struct packed {
    sdc_pkg::sdc_frame_type shift;
    sdc_pkg::sdc_frame_type cfg;
    logic pl_prev;
    logic sl_prev;
    logic sc_prev;
    logic ref_prev;
    logic vco_phase;
    logic [`SDC_M_W-1:0] fb_cnt;
    logic fb_out;
    logic observe;
    logic xtal_out;
    logic soft_rst;
    logic div_rst;
    logic half_tick;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [`SDC_DW-1:0] rdata;
  } sdc_state_type;

  localparam sdc_pkg::sdc_frame_type CFG_RST = '{
    t: `SDC_T_RST, n: `SDC_N_RST, m: `SDC_M_RST};

  sdc_state_type s;
  sdc_state_type n;
  logic fout_a;
  logic fout_a_comp;
  logic fout_b;
  logic fout_b_comp;

  // ========================================================
  // configuration, reference and observe logic
  logic pl_rise;
  logic sl_rise;
  logic sl_fall;
  logic sc_rise;
  logic ref_now;
  logic ref_edge;
  sdc_pkg::sdc_frame_type pin_f;
  sdc_pkg::sdc_frame_type shifted;
  sdc_pkg::sdc_status_type st;
  logic [`SDC_AW-1:0] wa;
  logic [`SDC_AW-1:0] ra;

  always_comb begin
    n = s;
    pl_rise = parallel_load_low_i && !s.pl_prev;
    sl_rise = serial_load_i && !s.sl_prev;
    sl_fall = !serial_load_i && s.sl_prev;
    sc_rise = serial_clock_i && !s.sc_prev;
    n.pl_prev = parallel_load_low_i;
    n.sl_prev = serial_load_i;
    n.sc_prev = serial_clock_i;
    pin_f.t = s.cfg.t;
    pin_f.n = {output_divide_select_high_i, output_divide_select_low_i};
    pin_f.m = feedback_divide_bits_i;
    // first bit in ends up in the top test bit after 13 clocks
    shifted = {s.shift[$bits(s.shift)-2:0], serial_data_i};
    // the divider reset never enters this branch on purpose
    if (!parallel_load_low_i) begin
      n.cfg = pin_f;
    end else if (pl_rise && !serial_load_i) begin
      n.cfg = pin_f;
    end else begin
      if (sc_rise) begin
        n.shift = shifted;
      end else begin
        n.shift = s.shift;
      end
      if (serial_load_i && sc_rise) begin
        n.cfg = shifted;
      end else if (sl_rise) begin
        n.cfg = s.shift;
      end else if (sl_fall) begin
        n.cfg = s.cfg;
      end
    end

    // reference source and its edges, both counted as half ticks
    ref_now = reference_source_select_i ? crystal_in_i
                                        : alt_ref_clock_i;
    n.ref_prev = ref_now;
    ref_edge = ref_now ^ s.ref_prev;
    n.xtal_out = !crystal_in_i;
    // vco stand-in ticks every other core cycle
    n.half_tick = pll_bypass_select_i ? 1'b1 : ref_edge;
    n.div_rst = divider_reset_i || s.soft_rst;
    if (s.div_rst) begin
      n.vco_phase = 1'b0;
      n.fb_cnt = '0;
      n.fb_out = 1'b0;
    end else if (pll_bypass_select_i) begin
      n.vco_phase = !s.vco_phase;
      // feedback count of vco ticks; lock means m ticks per ref
      if (s.vco_phase) begin
        if (`SDC_M_W'(s.fb_cnt + 1'b1) >= s.cfg.m) begin
          n.fb_cnt = '0;
        end else begin
          n.fb_cnt = `SDC_M_W'(s.fb_cnt + 1'b1);
        end
      end
      n.fb_out = n.fb_cnt < (s.cfg.m >> 1);
    end

    // observe routing, forced low in parallel mode
    if (!parallel_load_low_i) begin
      n.observe = 1'b0;
    end else begin
      unique case (s.cfg.t)
        `SDC_T_LOW: n.observe = 1'b0;
        `SDC_T_SDATA: n.observe = serial_data_i;
        `SDC_T_FB: n.observe = s.fb_out;
        `SDC_T_FOUT: n.observe = fout_a;
      endcase
    end

    // ======================================================
    // axi4-lite slave; one write and one read in flight
    wa = {axi_req_i.awaddr[`SDC_AW-1:2], 2'h0};
    ra = {axi_req_i.araddr[`SDC_AW-1:2], 2'h0};
    st.rsvd = '0;
    st.bypass = !pll_bypass_select_i;
    st.par_mode = !parallel_load_low_i;
    st.t = s.cfg.t;
    st.n = s.cfg.n;
    st.m = s.cfg.m;
    n.awready = 1'b0;
    n.wready = 1'b0;
    n.arready = 1'b0;
    if (s.bvalid && axi_req_i.bready) begin
      n.bvalid = 1'b0;
    end
    if (s.awready && axi_req_i.awvalid && axi_req_i.wvalid) begin
      n.bvalid = 1'b1;
      n.bresp = `SDC_RESP_OKAY;
      if (wa == `SDC_OFF_CTRL) begin
        if (axi_req_i.wstrb[0]) begin
          n.soft_rst = axi_req_i.wdata[`SDC_CTRL_SOFT_RST];
        end
      end else begin
        // status words are read only
        n.bresp = `SDC_RESP_SLVERR;
      end
    end else if (axi_req_i.awvalid && axi_req_i.wvalid
                 && !s.bvalid && !s.awready) begin
      n.awready = 1'b1;
      n.wready = 1'b1;
    end
    if (s.rvalid && axi_req_i.rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && axi_req_i.arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `SDC_RESP_OKAY;
      if (ra == `SDC_OFF_CTRL) begin
        n.rdata = `SDC_DW'(s.soft_rst);
      end else if (ra == `SDC_OFF_STATUS) begin
        n.rdata = st;
      end else if (ra == `SDC_OFF_SHIFT) begin
        n.rdata = `SDC_DW'(s.shift);
      end else begin
        n.rdata = '0;
        n.rresp = `SDC_RESP_SLVERR;
      end
    end else if (axi_req_i.arvalid && !s.rvalid && !s.arready) begin
      n.arready = 1'b1;
    end
  end

  // state register; only the system reset loads the reset configuration
  // strobe history starts high so no false parallel latch follows reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '{cfg: CFG_RST, pl_prev: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  // ========================================================
  // two independent output dividers on the same settings
  sdc_out_div u_div_a (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .div_rst_i(s.div_rst),
    .half_tick_i(s.half_tick),
    .ratio_sel_i(s.cfg.n),
    .clk_true_o(fout_a),
    .clk_comp_o(fout_a_comp)
  );

  sdc_out_div u_div_b (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .div_rst_i(s.div_rst),
    .half_tick_i(s.half_tick),
    .ratio_sel_i(s.cfg.n),
    .clk_true_o(fout_b),
    .clk_comp_o(fout_b_comp)
  );

  // outputs straight from flops
  assign clock_out_true_a_o = fout_a;
  assign clock_out_comp_a_o = fout_a_comp;
  assign clock_out_true_b_o = fout_b;
  assign clock_out_comp_b_o = fout_b_comp;
  assign crystal_out_o = s.xtal_out;
  assign observe_o = s.observe;
  assign axi_rsp_o = '{awready: s.awready, wready: s.wready,
    bvalid: s.bvalid, bresp: s.bresp, arready: s.arready,
    rvalid: s.rvalid, rdata: s.rdata, rresp: s.rresp};

  // ========================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_RST_OUTPUTS: assert property (
    divider_reset_i |-> ##2 (!clock_out_true_a_o && clock_out_comp_a_o
      && !clock_out_true_b_o && clock_out_comp_b_o))
    else $error("outputs not parked during divider reset");

  AST_RUN_TOGGLES: assert property (
    (!divider_reset_i && !s.soft_rst && pll_bypass_select_i)[*4]
    |-> ##[0:14] (clock_out_true_a_o != $past(clock_out_true_a_o)))
    else $error("output clock stalled while running");

  AST_CFG_KEEP: assert property (
    (divider_reset_i && parallel_load_low_i && s.pl_prev
     && !serial_load_i && !s.sl_prev) |=> $stable(s.cfg))
    else $error("divider reset disturbed the configuration");

  AST_REF_SELECT: assert property (
    (!pll_bypass_select_i && !reference_source_select_i
     && !$past(reference_source_select_i) && $stable(alt_ref_clock_i))
    |=> !s.half_tick)
    else $error("crystal edges leaked through with test clock selected");

  AST_PAR_PASS: assert property (
    !parallel_load_low_i |=> (s.cfg.m == $past(feedback_divide_bits_i)
      && !observe_o))
    else $error("parallel pins not passed or observe not low");

  AST_PAR_LATCH: assert property (
    (parallel_load_low_i && !s.pl_prev && !serial_load_i)
    |=> (s.cfg.m == $past(feedback_divide_bits_i)))
    else $error("parallel value not latched on load rise");

  AST_SHIFT_IN: assert property (
    (parallel_load_low_i && !serial_load_i && $rose(serial_clock_i))
    |=> (s.shift.m[0] == $past(serial_data_i)
      && s.shift.m[1] == $past(s.shift.m[0])))
    else $error("serial bit not shifted in");

  AST_SLOAD_XFER: assert property (
    (parallel_load_low_i && $rose(serial_load_i)
     && !$rose(serial_clock_i)) |=> s.cfg == $past(s.shift))
    else $error("shift register not transferred on load rise");

  AST_SHIFT_HOLD: assert property (
    (parallel_load_low_i && !$rose(serial_clock_i)) |=> $stable(s.shift))
    else $error("shift register changed with no serial clock");

  AST_PASS_THRU: assert property (
    (parallel_load_low_i && s.pl_prev && serial_load_i
     && $rose(serial_clock_i)) |=> (s.cfg.m[0] == $past(serial_data_i)))
    else $error("serial data not passed through");

  AST_OBS_FB: assert property (
    (parallel_load_low_i && s.cfg.t == `SDC_T_FB)
    |=> observe_o == $past(s.fb_out))
    else $error("observe does not show the feedback divider");
endmodule : sdc_loader

// file: verif/sdc_ctl_model.sv
// board controller model that drives the serial configuration pins
// ==========================================================
// serial frame driver
module sdc_ctl_model (
  input wire logic core_clk_i,
  output logic serial_clock_o,
  output logic serial_data_o,
  output logic serial_load_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels follow the pulldowns: clock stands still low
  initial begin
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
    serial_load_o = 1'b0;
  end
  // hold sets cycles per clock level, so the model runs fast or slow
  task automatic shift_frame(input sdc_pkg::sdc_frame_type f,
                             input int hold);
    int i;
    for (i = 12; i >= 0; i--) begin
      @(posedge core_clk_i);
      serial_data_o <= f[i]; // msb first, t bits lead
      serial_clock_o <= 1'b0;
      repeat (hold) @(posedge core_clk_i);
      serial_clock_o <= 1'b1; // data set up before the rise
      repeat (hold) @(posedge core_clk_i);
    end
    @(posedge core_clk_i);
    serial_clock_o <= 1'b0;
    serial_data_o <= 1'b0; // released line falls to its pulldown
  endtask : shift_frame
  // null slot kept before the strobe, no clock edge near it
  task automatic load_frame();
    repeat (3) @(posedge core_clk_i);
    serial_load_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    serial_load_o <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask : load_frame
  // strobe held high turns every clock rise into a pass-through load
  task automatic set_load(input logic v);
    @(posedge core_clk_i);
    serial_load_o <= v;
  endtask : set_load
  // observation traffic only, never during a frame
  task automatic drive_data(input logic v);
    @(posedge core_clk_i);
    serial_data_o <= v;
  endtask : drive_data
endmodule : sdc_ctl_model

// file: verif/testbench.sv
// self-checking bench for the divider configuration loader
`include "sdc_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, div_rst, load_low, n_lo, n_hi, ref_sel, byp_sel;
  logic xtal, alt, xo, ta, ca, tb, cb, obs, sclk, sdata, sload;
  logic [8:0] m_pins;
  logic [3:0] xcnt;
  sdc_pkg::sdc_axi_req_type req;
  sdc_pkg::sdc_axi_rsp_type rsp;
  int mismatches, n_checks, cyc;
  // ========================================================
  // clock, reset and crystal stand-in
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1; div_rst = 1'b0; load_low = 1'b1; m_pins = 9'h000;
    n_lo = 1'b0; n_hi = 1'b0; ref_sel = 1'b1; byp_sel = 1'b1;
    alt = 1'b0; xcnt = 4'h0; req = '0;
  end
  // crystal toggles every four cycles, far below the core rate
  always @(posedge clk) xcnt <= xcnt + 4'h1;
  assign xtal = xcnt[2];
  // hang guard: the tests need well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  sdc_loader u_sdc_loader (.core_clk_i(clk), .sys_rst_i(rst),
    .axi_req_i(req), .axi_rsp_o(rsp), .divider_reset_i(div_rst),
    .parallel_load_low_i(load_low), .feedback_divide_bits_i(m_pins),
    .output_divide_select_low_i(n_lo), .output_divide_select_high_i(n_hi),
    .serial_clock_i(sclk), .serial_data_i(sdata), .serial_load_i(sload),
    .reference_source_select_i(ref_sel), .pll_bypass_select_i(byp_sel),
    .crystal_in_i(xtal), .alt_ref_clock_i(alt), .crystal_out_o(xo),
    .clock_out_true_a_o(ta), .clock_out_comp_a_o(ca),
    .clock_out_true_b_o(tb), .clock_out_comp_b_o(cb), .observe_o(obs));
  sdc_ctl_model u_sdc_ctl_model (.core_clk_i(clk),
    .serial_clock_o(sclk), .serial_data_o(sdata), .serial_load_o(sload));
  // ========================================================
  // shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    @(posedge clk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1;
    req.wdata <= d; req.wstrb <= 4'hF; req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    chk(32'(rsp.bresp), 32'(er));
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    @(posedge clk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    chk(rsp.rdata, ed);
    chk(32'(rsp.rresp), 32'(er));
  endtask : axi_rd
  // bounded wait for output a true to reach a level
  task automatic wait_ta(input logic v);
    int i;
    i = 0;
    while (ta !== v && i < 60) begin
      @(posedge clk);
      i++;
    end
  endtask : wait_ta
  task automatic count_tog(output int n);
    logic p;
    n = 0;
    p = ta;
    repeat (200) begin
      @(posedge clk);
      if (ta !== p) n++;
      p = ta;
    end
  endtask : count_tog
  task automatic count_obs(output int n);
    logic p;
    n = 0;
    p = obs;
    repeat (200) begin
      @(posedge clk);
      if (obs !== p) n++;
      p = obs;
    end
  endtask : count_obs
  // ========================================================
  // scenarios
  task automatic t_reset_map();
    axi_rd(`SDC_OFF_STATUS, 32'h0000_0219, `SDC_RESP_OKAY);
    axi_rd(`SDC_OFF_SHIFT, 32'h0, `SDC_RESP_OKAY);
    axi_rd(12'h010, 32'h0, `SDC_RESP_SLVERR);
    axi_wr(`SDC_OFF_STATUS, 32'hFFFF_FFFF, `SDC_RESP_SLVERR);
    axi_rd(`SDC_OFF_STATUS, 32'h0000_0219, `SDC_RESP_OKAY);
    $display("test reset_map done");
  endtask : t_reset_map
  task automatic t_parallel();
    int k, h;
    @(posedge clk);
    load_low <= 1'b0; m_pins <= 9'h01B; {n_hi, n_lo} <= 2'h2;
    repeat (3) @(posedge clk);
    axi_rd(`SDC_OFF_STATUS, 32'h0000_241B, `SDC_RESP_OKAY);
    chk(32'(obs), 32'h0);
    // every select code, high time counted in core cycles
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      {n_hi, n_lo} <= 2'(k);
      repeat (30) @(posedge clk);
      wait_ta(1'b0);
      wait_ta(1'b1);
      h = 0;
      while (ta === 1'b1 && h < 20) begin
        @(posedge clk);
        h++;
      end
      chk(32'(h), 32'(k + 3));
      chk({29'h0, ca, tb, cb}, {29'h0, ~ta, ta, ~ta});
    end
    @(posedge clk);
    {n_hi, n_lo} <= 2'h2;
    repeat (2) @(posedge clk);
    load_low <= 1'b1;
    repeat (2) @(posedge clk);
    m_pins <= 9'h1FF;
    repeat (3) @(posedge clk);
    axi_rd(`SDC_OFF_STATUS, 32'h0000_041B, `SDC_RESP_OKAY);
    axi_rd(`SDC_OFF_SHIFT, 32'h0, `SDC_RESP_OKAY);
    $display("test parallel done");
  endtask : t_parallel
  task automatic t_serial();
    u_sdc_ctl_model.shift_frame(13'h0E1F, 1);
    axi_rd(`SDC_OFF_SHIFT, 32'h0000_0E1F, `SDC_RESP_OKAY);
    axi_rd(`SDC_OFF_STATUS, 32'h0000_041B, `SDC_RESP_OKAY);
    u_sdc_ctl_model.load_frame();
    axi_rd(`SDC_OFF_STATUS, 32'h0000_0E1F, `SDC_RESP_OKAY);
    u_sdc_ctl_model.shift_frame(13'h081A, 3);
    u_sdc_ctl_model.load_frame();
    axi_rd(`SDC_OFF_STATUS, 32'h0000_081A, `SDC_RESP_OKAY);
    // test bits now 01: observe follows the serial data line
    u_sdc_ctl_model.drive_data(1'b1);
    repeat (3) @(posedge clk);
    chk(32'(obs), 32'h1);
    u_sdc_ctl_model.drive_data(1'b0);
    repeat (3) @(posedge clk);
    chk(32'(obs), 32'h0);
    $display("test serial done");
  endtask : t_serial
  task automatic t_div_reset();
    @(posedge clk);
    div_rst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({28'h0, ta, ca, tb, cb}, 32'h5);
    axi_rd(`SDC_OFF_STATUS, 32'h0000_081A, `SDC_RESP_OKAY);
    @(posedge clk);
    div_rst <= 1'b0;
    wait_ta(1'b1);
    chk(32'(ta), 32'h1);
    axi_wr(`SDC_OFF_CTRL, 32'h1, `SDC_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk({28'h0, ta, ca, tb, cb}, 32'h5);
    axi_rd(`SDC_OFF_CTRL, 32'h1, `SDC_RESP_OKAY);
    axi_wr(`SDC_OFF_CTRL, 32'h0, `SDC_RESP_OKAY);
    $display("test div_reset done");
  endtask : t_div_reset
  task automatic t_reference();
    int n;
    @(posedge clk);
    byp_sel <= 1'b0;
    repeat (20) @(posedge clk);
    axi_rd(`SDC_OFF_STATUS, 32'h0000_481A, `SDC_RESP_OKAY);
    count_tog(n);
    chk(32'(n != 0), 32'h1);
    // the test clock input stands still, so the output must too
    @(posedge clk);
    ref_sel <= 1'b0;
    repeat (20) @(posedge clk);
    count_tog(n);
    chk(32'(n), 32'h0);
    $display("test reference done");
  endtask : t_reference
  // serial load held high: each clock rise lands in the dividers
  task automatic t_observe();
    int n;
    logic p;
    @(posedge clk);
    byp_sel <= 1'b1; ref_sel <= 1'b1;
    u_sdc_ctl_model.set_load(1'b1);
    u_sdc_ctl_model.shift_frame(13'h1A19, 1);
    u_sdc_ctl_model.set_load(1'b0);
    axi_rd(`SDC_OFF_STATUS, 32'h0000_1A19, `SDC_RESP_OKAY);
    // test bits 11: observe follows output a, four cycles per level
    repeat (20) @(posedge clk);
    count_obs(n);
    chk(32'(n), 32'h32);
    // test bits 10: feedback output, 25 vco ticks of two cycles each
    u_sdc_ctl_model.set_load(1'b1);
    u_sdc_ctl_model.shift_frame(13'h1219, 1);
    u_sdc_ctl_model.set_load(1'b0);
    axi_rd(`SDC_OFF_STATUS, 32'h0000_1219, `SDC_RESP_OKAY);
    repeat (60) @(posedge clk);
    count_obs(n);
    chk(32'(n), 32'h8);
    // crystal output is the registered inverse of the crystal input
    @(posedge clk);
    p = xtal;
    @(posedge clk);
    chk({31'h0, xo}, {31'h0, ~p});
    $display("test observe done");
  endtask : t_observe
  // ========================================================
  // verdict
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    mismatches = 0; n_checks = 0; cyc = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset_map();
    t_parallel();
    t_serial();
    t_div_reset();
    t_reference();
    t_observe();
    report_and_stop();
  end
endmodule : testbench
